/* File: rtl/thermal_pkg.sv */
`default_nettype none
package thermal_pkg;

    // clock and conversion timing
    localparam int      CLK_PERIOD_NS   = 20;
    localparam longint  BASE_PERIOD_NS  = 62500000; // 1/16 s, code 0000
    localparam int      BASE_PERIOD_CYC = int'(BASE_PERIOD_NS / CLK_PERIOD_NS);

    // bus address, arbitrary value
    localparam logic [6:0] DEV_ADDR_DEF = 7'h4C;

    // register offsets
    localparam logic [7:0] REG_AVG_CFG    = 8'h06;
    localparam logic [7:0] REG_CRIT_LIMIT = 8'h07;
    localparam logic [7:0] REG_CRIT_HYST  = 8'h0C;
    localparam logic [7:0] REG_STATUS     = 8'h0E;
    localparam logic [7:0] REG_CONTROL    = 8'h0F;
    localparam logic [7:0] REG_TEMP_LOW   = 8'h10;
    localparam logic [7:0] REG_RATE_TEMP  = 8'h11;

    // reset values and rate code limit
    localparam logic [7:0] AVG_CFG_RST    = 8'h00;
    localparam logic [6:0] CRIT_LIMIT_RST = 7'h7F;
    localparam logic [7:0] CRIT_HYST_RST  = 8'h04;
    localparam logic [3:0] RATE_RST       = 4'h2;
    localparam logic [3:0] RATE_MAX       = 4'hA;

    // field positions and result width
    localparam int CTL_FAULT_CLR = 7;
    localparam int CTL_STANDBY   = 6;
    localparam int CTL_DYN_AVG   = 5;
    localparam int CTL_ONE_SHOT  = 4;
    localparam int RATE_LSB      = 1;
    localparam int ST_HIGH       = 6;
    localparam int ST_LOW        = 5;
    localparam int ST_CRIT       = 2;
    localparam int HYST_MASK_BIT = 7;
    localparam int TEMP_W        = 11;

    typedef enum logic [8:0] {
        I2C_IDLE     = 9'h001,
        I2C_ADDR     = 9'h002,
        I2C_ACK_ADDR = 9'h004,
        I2C_REG      = 9'h008,
        I2C_ACK_REG  = 9'h010,
        I2C_WDATA    = 9'h020,
        I2C_ACK_W    = 9'h040,
        I2C_RDATA    = 9'h080,
        I2C_ACK_R    = 9'h100
    } i2c_state_t;

    typedef enum logic [1:0] {
        CONV_IDLE = 2'h1,
        CONV_WAIT = 2'h2
    } conv_state_t;

    typedef struct packed {
        i2c_state_t        i2c;
        logic [7:0]        sh;
        logic [3:0]        bitcnt;
        logic              rw;
        logic              nack;
        logic [7:0]        ptr;
        logic              sda_oe;
        logic              sda_out;
        logic              scl_d;
        logic              sda_d;
        logic [7:0]        avg_cfg;
        logic [6:0]        crit_limit;
        logic [7:0]        crit_hyst;
        logic              standby;
        logic              dyn_avg;
        logic [3:0]        rate;
        logic              crit_flag;
        logic              high_flag;
        logic              low_flag;
        logic              crit_armed;
        logic              shutdown_n;
        logic              alert_clear;
        conv_state_t       conv;
        logic [31:0]       timer;
        logic [4:0]        remaining;
        logic [14:0]       acc;
        logic [TEMP_W-1:0] temp;
        logic              conv_start;
        logic              one_shot;
    } state_t;

    localparam state_t STATE_RST = '{
        i2c: I2C_IDLE, sh: 8'h00, bitcnt: 4'h0, rw: 1'b0, nack: 1'b0,
        ptr: 8'h00, sda_oe: 1'b0, sda_out: 1'b0, scl_d: 1'b1,
        sda_d: 1'b1, avg_cfg: AVG_CFG_RST, crit_limit: CRIT_LIMIT_RST,
        crit_hyst: CRIT_HYST_RST, standby: 1'b0, dyn_avg: 1'b0,
        rate: RATE_RST, crit_flag: 1'b0, high_flag: 1'b0,
        low_flag: 1'b0, crit_armed: 1'b1, shutdown_n: 1'b1,
        alert_clear: 1'b0, conv: CONV_IDLE, timer: 32'h0000_0000,
        remaining: 5'h00, acc: 15'h0000, temp: 11'h000,
        conv_start: 1'b0, one_shot: 1'b0};

endpackage : thermal_pkg
`default_nettype wire

/* File: rtl/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int               WIDTH      = 2,
    parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } sync_t;

    sync_t st;
    sync_t nx;

    // a bit only moves once two late stages agree, masking glitches
    always_comb
    begin
        nx    = st;
        nx.s1 = d;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st.s2[i] == st.s3[i])
                nx.lvl[i] = st.s3[i];
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st <= '{IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL, IDLE_LEVEL};
        else
            st <= nx;
    end

    assign q = st.lvl;

endmodule : pin_sync
`default_nettype wire

/* File: rtl/thermal_ctrl.sv */
// Function
// - critical limit, 7 bits at byte 7
// - critical limit resets to 127 degrees
// - hysteresis 5 bits at byte 12, reset 4
// - critical event sets status byte 14 bit 2
// - shutdown low latched until byte 15 bit 7
// - same clear wipes threshold alert flags
// - byte 15 bit 6 selects standby mode
// - active mode converts at programmed rate
// - standby runs one conversion burst per host request
// - byte 17 bits 4:1 pick conversion rate
// - averaging only with byte 15 bit 5
// - byte 6 bits 1:0 pick 1/4/8/16
// - results are 11 bits, eighth degree steps
`timescale 1ns/100ps
`default_nettype none
module thermal_ctrl
    import thermal_pkg::*;
#(
    parameter logic [6:0]  DEV_ADDR           = DEV_ADDR_DEF,
    parameter int unsigned BASE_PERIOD_CYCLES = BASE_PERIOD_CYC
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output var  logic              sda_out,
    output var  logic              sda_oe,
    output var  logic              shutdown_n,
    output var  logic              alert_clear,
    output var  logic              conv_start,
    input  wire logic              conv_done,
    input  wire logic [TEMP_W-1:0] conv_code,
    input  wire logic              alert_high_event,
    input  wire logic              alert_low_event
);

    state_t            st;
    state_t            n;
    logic [1:0]        pins;
    logic              scl;
    logic              sda;
    logic              scl_rise;
    logic              scl_fall;
    logic              start_cond;
    logic              stop_cond;
    logic [7:0]        rd_byte;
    logic              wr;
    logic              fault_clr;
    logic              tick;
    logic              request;
    logic [3:0]        rate_eff;
    logic [31:0]       period;
    logic [2:0]        avg_shift;
    logic [4:0]        avg_count;
    logic [14:0]       acc_sum;
    logic [TEMP_W-1:0] result;
    logic              new_result;
    logic              crit_event;
    logic [6:0]        low_deg;
    logic [TEMP_W-1:0] trip_thr;
    logic [TEMP_W-1:0] rearm_thr;

    // bus pins come from another domain, three stages each
    pin_sync #(
        .WIDTH      (2),
        .IDLE_LEVEL (2'h3)
    ) u_sync (
        .clk   (clk),
        .reset (reset),
        .d     ({scl_in, sda_in}),
        .q     (pins)
    );

    assign scl        = pins[1];
    assign sda        = pins[0];
    assign scl_rise   = scl & ~st.scl_d;
    assign scl_fall   = ~scl & st.scl_d;
    assign start_cond = scl & st.scl_d & st.sda_d & ~sda;
    assign stop_cond  = scl & st.scl_d & ~st.sda_d & sda;

    // read mux, reserved bits read zero except at byte 6, which reads back all 8 written bits
    always_comb
    begin
        case (st.ptr)
            REG_AVG_CFG:    rd_byte = st.avg_cfg;
            REG_CRIT_LIMIT: rd_byte = {1'b0, st.crit_limit};
            REG_CRIT_HYST:  rd_byte = {st.crit_hyst[HYST_MASK_BIT],
                                       2'h0, st.crit_hyst[4:0]};
            REG_STATUS:     rd_byte = {1'b0, st.high_flag, st.low_flag,
                                       2'h0, st.crit_flag, 2'h0};
            REG_CONTROL:    rd_byte = {1'b0, st.standby, st.dyn_avg, 5'h00};
            REG_TEMP_LOW:   rd_byte = st.temp[7:0];
            REG_RATE_TEMP:  rd_byte = {st.temp[10:8], st.rate, 1'b0};
            default:        rd_byte = 8'h00;
        endcase
    end

    // rate code doubles the period, clamped at the slowest
    assign rate_eff = (st.rate > RATE_MAX) ? RATE_MAX : st.rate;
    assign period   = 32'(BASE_PERIOD_CYCLES) << rate_eff;
    assign tick     = ~st.standby && (st.timer == 32'h0000_0000);

    // averaging count, forces one when disabled
    always_comb
    begin
        case (st.avg_cfg[1:0])
            2'h0:    avg_shift = 3'h0;
            2'h1:    avg_shift = 3'h2;
            2'h2:    avg_shift = 3'h3;
            default: avg_shift = 3'h4;
        endcase
        // only the enable bit turns averaging on
        if (!st.dyn_avg)
            avg_shift = 3'h0;
        avg_count = 5'h01 << avg_shift;
    end

    // accumulate 11 bit codes, sum of 16 fits 15 bits
    assign acc_sum    = st.acc + {4'h0, conv_code};
    assign result     = TEMP_W'(acc_sum >> avg_shift);
    assign new_result = (st.conv == CONV_WAIT) && conv_done &&
                        (st.remaining == 5'h00);

    // thresholds in eighths of a degree; underflow never rearms
    assign trip_thr  = {1'b0, st.crit_limit, 3'h0};
    assign low_deg   = st.crit_limit - {2'h0, st.crit_hyst[4:0]};
    assign rearm_thr = (st.crit_limit > {2'h0, st.crit_hyst[4:0]}) ?
                       {1'b0, low_deg, 3'h0} : {TEMP_W{1'b0}};
    assign crit_event = new_result && st.crit_armed && (result >= trip_thr);

    assign wr        = (st.i2c == I2C_WDATA) && scl_fall &&
                       (st.bitcnt == 4'h8) && ~start_cond && ~stop_cond;
    assign fault_clr = wr && (st.ptr == REG_CONTROL) && st.sh[CTL_FAULT_CLR];
    assign request   = tick || st.one_shot;

    always_comb
    begin
        n             = st;
        n.conv_start  = 1'b0;
        n.alert_clear = 1'b0;
        n.scl_d       = scl;
        n.sda_d       = sda;

        // bus slave: start restarts address phase anywhere
        if (start_cond)
        begin
            n.i2c    = I2C_ADDR;
            n.bitcnt = 4'h0;
            n.sda_oe = 1'b0;
        end
        else if (stop_cond)
        begin
            n.i2c    = I2C_IDLE;
            n.sda_oe = 1'b0;
        end
        else
        begin
            case (st.i2c)
                I2C_IDLE:
                    n.i2c = I2C_IDLE;
                I2C_ADDR, I2C_REG, I2C_WDATA:
                begin
                    if (scl_rise)
                    begin
                        n.sh     = {st.sh[6:0], sda};
                        n.bitcnt = st.bitcnt + 4'h1;
                    end
                    else if (scl_fall && st.bitcnt == 4'h8)
                    begin
                        n.bitcnt = 4'h0;
                        n.sda_oe = 1'b1;
                        if (st.i2c == I2C_ADDR)
                        begin
                            n.rw  = st.sh[0];
                            n.i2c = I2C_ACK_ADDR;
                            if (st.sh[7:1] != DEV_ADDR)
                            begin
                                n.i2c    = I2C_IDLE;
                                n.sda_oe = 1'b0;
                            end
                        end
                        else if (st.i2c == I2C_REG)
                        begin
                            n.ptr = st.sh;
                            n.i2c = I2C_ACK_REG;
                        end
                        else
                            n.i2c = I2C_ACK_W;
                    end
                end
                I2C_ACK_ADDR:
                begin
                    if (scl_fall && st.rw)
                    begin
                        n.i2c    = I2C_RDATA;
                        n.sh     = rd_byte;
                        n.sda_oe = ~rd_byte[7];
                    end
                    else if (scl_fall)
                    begin
                        n.i2c    = I2C_REG;
                        n.sda_oe = 1'b0;
                    end
                end
                I2C_ACK_REG, I2C_ACK_W:
                begin
                    if (scl_fall)
                    begin
                        n.i2c    = I2C_WDATA;
                        n.sda_oe = 1'b0;
                        if (st.i2c == I2C_ACK_W)
                            n.ptr = st.ptr + 8'h01;
                    end
                end
                I2C_RDATA:
                begin
                    if (scl_rise)
                        n.bitcnt = st.bitcnt + 4'h1;
                    else if (scl_fall && st.bitcnt == 4'h8)
                    begin
                        n.bitcnt = 4'h0;
                        n.sda_oe = 1'b0;
                        n.ptr    = st.ptr + 8'h01;
                        n.i2c    = I2C_ACK_R;
                    end
                    else if (scl_fall)
                    begin
                        n.sh     = {st.sh[6:0], 1'b0};
                        n.sda_oe = ~st.sh[6];
                    end
                end
                I2C_ACK_R:
                begin
                    if (scl_rise)
                        n.nack = sda;
                    else if (scl_fall && st.nack)
                        n.i2c = I2C_IDLE;
                    else if (scl_fall)
                    begin
                        n.i2c    = I2C_RDATA;
                        n.sh     = rd_byte;
                        n.sda_oe = ~rd_byte[7];
                    end
                end
                default:
                    n.i2c = I2C_IDLE;
            endcase
        end

        // register writes
        if (wr)
        begin
            case (st.ptr)
                REG_AVG_CFG:    n.avg_cfg = st.sh;
                REG_CRIT_LIMIT: n.crit_limit = st.sh[6:0];
                REG_CRIT_HYST:  n.crit_hyst = st.sh;
                REG_CONTROL:
                begin
                    n.standby = st.sh[CTL_STANDBY];
                    n.dyn_avg = st.sh[CTL_DYN_AVG];
                    if (st.sh[CTL_ONE_SHOT])
                        n.one_shot = 1'b1;
                end
                REG_RATE_TEMP:  n.rate = st.sh[4:1];
                default:        n.rate = st.rate;
            endcase
        end

        // free running period timer in active mode
        if (st.standby)
            n.timer = 32'h0000_0000;
        else if (tick)
            n.timer = period - 32'h0000_0001;
        else
            n.timer = st.timer - 32'h0000_0001;

        // conversion burst; a timer tick during a burst is dropped, a one-shot request waits for the burst to end
        case (st.conv)
            CONV_IDLE:
            begin
                if (request)
                begin
                    n.one_shot   = 1'b0;
                    n.acc        = 15'h0000;
                    n.remaining  = avg_count - 5'h01;
                    n.conv_start = 1'b1;
                    n.conv       = CONV_WAIT;
                end
            end
            CONV_WAIT:
            begin
                if (conv_done && st.remaining == 5'h00)
                begin
                    n.temp = result;
                    n.conv = CONV_IDLE;
                end
                else if (conv_done)
                begin
                    n.acc        = acc_sum;
                    n.remaining  = st.remaining - 5'h01;
                    n.conv_start = 1'b1;
                end
            end
            default:
                n.conv = CONV_IDLE;
        endcase

        // disarm on trip, rearm below hysteresis band
        if (crit_event)
            n.crit_armed = 1'b0;
        else if (new_result && result < rearm_thr)
            n.crit_armed = 1'b1;

        // sticky critical flag, set beats clear
        n.crit_flag = crit_event | (st.crit_flag & ~fault_clr);
        // threshold flags cleared by the fault clear
        n.high_flag   = alert_high_event | (st.high_flag & ~fault_clr);
        n.low_flag    = alert_low_event | (st.low_flag & ~fault_clr);
        n.alert_clear = fault_clr;

        // shutdown latched low until host clears
        if (crit_event)
            n.shutdown_n = 1'b0;
        else if (fault_clr)
            n.shutdown_n = 1'b1;
    end

    // reset state carries the 127 degree limit
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            st <= STATE_RST;
        else
            st <= n;
    end

    assign sda_out     = st.sda_out;
    assign sda_oe      = st.sda_oe;
    assign shutdown_n  = st.shutdown_n;
    assign alert_clear = st.alert_clear;
    assign conv_start  = st.conv_start;

endmodule : thermal_ctrl
`default_nettype wire

/* File: verification/thermal_ctrl_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module thermal_ctrl_asserts
    import thermal_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic shutdown_n,
    input wire logic alert_clear,
    input wire logic conv_start,
    input wire logic conv_done
);
    // open conversion, so a second start can be caught
    logic busy_reg;
    always_ff @(posedge clk or posedge reset)
        if (reset)
            busy_reg <= 1'b0;
        else
            busy_reg <= conv_start | (busy_reg & ~conv_done);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // pin is open drain, only the enable ever moves
    a_sda_open_drain:
        assert property (sda_out == 1'b0)
        else $error("sda_out not held low");
    a_sda_scl_low:
        assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda_oe moved while scl high");
    a_ack_stands:
        assert property ($rose(sda_oe) |-> sda_oe [*8])
        else $error("sda_oe dropped too early");
    a_start_one_cycle:
        assert property (conv_start |=> !conv_start)
        else $error("conv_start longer than one cycle");
    a_start_not_busy:
        assert property (conv_start |-> !busy_reg)
        else $error("conv_start while conversion open");
    a_clear_one_cycle:
        assert property (alert_clear |=> !alert_clear)
        else $error("alert_clear longer than one cycle");
    a_shut_holds_low:
        assert property (!shutdown_n && !alert_clear
                         |=> !shutdown_n || alert_clear)
        else $error("shutdown_n released without clear");
    a_shut_after_done:
        assert property ($fell(shutdown_n) |-> $past(conv_done))
        else $error("shutdown_n fell without a result");
    a_clear_releases:
        assert property (alert_clear |-> shutdown_n || $past(conv_done))
        else $error("shutdown_n not released by clear");
    a_rise_by_clear:
        assert property ($rose(shutdown_n)
                         |-> alert_clear || $past(alert_clear))
        else $error("shutdown_n rose with no clear");

    c_trip: cover property ($fell(shutdown_n));
    c_clear: cover property (alert_clear);
    c_ack: cover property ($rose(sda_oe));
endmodule : thermal_ctrl_asserts

bind thermal_ctrl thermal_ctrl_asserts chk (
    .clk, .reset, .scl_in, .sda_out, .sda_oe, .shutdown_n,
    .alert_clear, .conv_start, .conv_done
);
`default_nettype wire

/* File: verification/i2c_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model
    import thermal_pkg::*;
#(
    parameter int HALF = 10
) (
    input  wire logic clk,
    input  wire logic sda_wire,
    output var  logic scl,
    output var  logic sda_m
);
    // bus starts released, both lines high
    initial
    begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    // every change lands just after an edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // data moves only with scl low; sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        tick(HALF);
        sda_m = b;
        tick(HALF);
        scl = 1'b1;
        tick(HALF / 2);
        r = sda_wire;
        tick(HALF / 2);
        scl = 1'b0;
    endtask : bit_io

    // msb first, ninth bit is the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic last,
                           output logic [7:0] q);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(last, a);
    endtask : byte_io

    // also serves as repeated start
    task automatic start();
        tick(HALF);
        sda_m = 1'b1;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_m = 1'b0;
        tick(HALF);
        scl = 1'b0;
    endtask : start

    task automatic stop();
        tick(HALF);
        sda_m = 1'b0;
        tick(HALF);
        scl = 1'b1;
        tick(HALF);
        sda_m = 1'b1;
        tick(HALF);
    endtask : stop

    task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d);
        logic [7:0] q;
        start();
        byte_io({DEV_ADDR_DEF, 1'b0}, 1'b1, q);
        byte_io(ptr, 1'b1, q);
        byte_io(d, 1'b1, q);
        stop();
    endtask : write_reg

    // single byte read, host ends it with a nack
    task automatic read_reg(input logic [7:0] ptr, output logic [7:0] d);
        logic [7:0] q;
        start();
        byte_io({DEV_ADDR_DEF, 1'b0}, 1'b1, q);
        byte_io(ptr, 1'b1, q);
        start();
        byte_io({DEV_ADDR_DEF, 1'b1}, 1'b1, q);
        byte_io(8'hFF, 1'b1, d);
        stop();
    endtask : read_reg
endmodule : i2c_host_model
`default_nettype wire

/* File: verification/thermal_ctrl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module thermal_ctrl_tb
    import thermal_pkg::*;
;
    localparam int BASE = 8;
    logic              clk, reset, scl, sda_m, sda_out, sda_oe;
    logic              shutdown_n, alert_clear, conv_start;
    logic              conv_done, hi_ev, lo_ev;
    logic [TEMP_W-1:0] conv_code, adc_base;
    logic [2:0]        pipe;
    int                n_errors, tests_run, n_starts, n_clears, quiet;
    wire logic         sda_wire = sda_m & ~sda_oe; // pull-up

    thermal_ctrl #(.BASE_PERIOD_CYCLES(BASE)) dut (
        .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .shutdown_n(shutdown_n),
        .alert_clear(alert_clear), .conv_start(conv_start),
        .conv_done(conv_done), .conv_code(conv_code),
        .alert_high_event(hi_ev), .alert_low_event(lo_ev));
    i2c_host_model host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
        .sda_m(sda_m));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // adc stand-in: result four cycles on, ramps within a burst
    always @(posedge clk)
    begin
        pipe <= {pipe[1:0], conv_start};
        conv_done <= #1 pipe[2];
        conv_code <= #1 pipe[2] ? adc_base + 11'((n_starts - 1) % 16)
                                : ~conv_code; // no stale code
        if (conv_start === 1'b1)
            n_starts <= n_starts + 1;
        if (alert_clear === 1'b1)
            n_clears <= n_clears + 1;
        quiet <= (conv_start || conv_done) ? 0 : quiet + 1;
    end

    task automatic give_verdict();
        $display("tests %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic give_up(input string what);
        n_errors++;
        $display("mismatch %s expected event seen timeout", what);
        give_verdict();
    endtask : give_up

    task automatic chk_byte(input string what, input logic [7:0] e,
                            input logic [7:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic chk_count(input string what, input int e, input int g);
        tests_run++;
        if (g != e)
        begin
            n_errors++;
            $display("mismatch %s expected %0d seen %0d", what, e, g);
        end
    endtask : chk_count

    task automatic rd(input logic [7:0] ptr, input logic [7:0] e);
        logic [7:0] d;
        host.read_reg(ptr, d);
        chk_byte($sformatf("reg %h", ptr), e, d);
    endtask : rd

    // quiet means a whole burst has finished
    task automatic wait_quiet();
        for (int i = 0; i < 3000; i++)
        begin
            @(posedge clk);
            if (quiet > 20)
                return;
        end
        give_up("burst end");
    endtask : wait_quiet

    task automatic wait_start(input int bound);
        for (int i = 0; i < bound; i++)
        begin
            @(posedge clk);
            if (conv_start === 1'b1)
                return;
        end
        give_up("conv_start");
    endtask : wait_start

    task automatic one_shot(input logic [7:0] ctl, input logic [10:0] b,
                            input int n);
        n_starts = 0;
        adc_base = b;
        host.write_reg(REG_CONTROL, ctl);
        wait_quiet();
        chk_count("conversions", n, n_starts);
    endtask : one_shot

    task automatic crit(input logic [10:0] code, input logic e);
        one_shot(8'h50, code, 1);
        chk_bit("shutdown_n", e, shutdown_n);
    endtask : crit

    task automatic t_reset();
        rd(REG_AVG_CFG, 8'h00);
        rd(REG_CRIT_LIMIT, 8'h7F);
        rd(REG_CRIT_HYST, 8'h04);
        rd(REG_STATUS, 8'h00);
        rd(REG_CONTROL, 8'h00);
        rd(REG_RATE_TEMP, 8'h04);
        rd(8'h20, 8'h00);
        host.write_reg(REG_CRIT_LIMIT, 8'hFF);
        rd(REG_CRIT_LIMIT, 8'h7F);
        host.write_reg(REG_CRIT_HYST, 8'hFF);
        rd(REG_CRIT_HYST, 8'h9F);
        host.write_reg(REG_CRIT_HYST, 8'h04);
        $display("test reset done");
    endtask : t_reset

    // interval between two starts right after a rate change
    task automatic t_rate();
        int c;
        for (int k = 0; k <= 10; k++)
        begin
            host.write_reg(REG_RATE_TEMP, 8'(k << RATE_LSB));
            wait_start(BASE << 11);
            for (c = 1; c < (BASE << 11); c++)
            begin
                @(posedge clk);
                if (conv_start === 1'b1)
                    break;
            end
            chk_count("rate period", BASE << k, c);
        end
        host.write_reg(REG_RATE_TEMP, 8'h04);
        $display("test rate done");
    endtask : t_rate

    task automatic t_standby();
        host.write_reg(REG_CONTROL, 8'h40);
        wait_quiet();
        n_starts = 0;
        repeat (400) @(posedge clk);
        chk_count("standby starts", 0, n_starts);
        one_shot(8'h50, 11'h3A5, 1);
        rd(REG_TEMP_LOW, 8'hA5);
        rd(REG_RATE_TEMP, 8'h64);
        rd(REG_CONTROL, 8'h40);
        $display("test standby done");
    endtask : t_standby

    // ramping codes make the mean differ for each count
    task automatic t_avg();
        int n;
        for (int c = 0; c < 4; c++)
        begin
            n = (c == 0) ? 1 : (2 << c);
            host.write_reg(REG_AVG_CFG, 8'(c));
            one_shot(8'h70, 11'h040, n);
            rd(REG_TEMP_LOW, 8'(64 + (n - 1) / 2));
        end
        one_shot(8'h50, 11'h040, 1);
        rd(REG_TEMP_LOW, 8'h40);
        $display("test averaging done");
    endtask : t_avg

    // limit 32 degrees, hysteresis 4: rearm below code 224
    task automatic t_crit();
        host.write_reg(REG_CRIT_LIMIT, 8'h20);
        crit(11'h0FF, 1'b1);
        @(posedge clk);
        #1 {hi_ev, lo_ev} = 2'b11;
        @(posedge clk);
        #1 {hi_ev, lo_ev} = 2'b00;
        crit(11'h100, 1'b0);
        rd(REG_STATUS, 8'h64);
        n_clears = 0;
        host.write_reg(REG_CONTROL, 8'hC0);
        chk_count("clear pulses", 1, n_clears);
        chk_bit("shutdown_n", 1'b1, shutdown_n);
        rd(REG_STATUS, 8'h00);
        crit(11'h12C, 1'b1);
        crit(11'h0E0, 1'b1);
        crit(11'h100, 1'b1);
        crit(11'h0DF, 1'b1);
        crit(11'h100, 1'b0);
        rd(REG_STATUS, 8'h04);
        $display("test critical done");
    endtask : t_crit

    initial
    begin
        reset = 1'b1;
        {hi_ev, lo_ev, conv_done} = 3'b000;
        conv_code = 11'h000;
        pipe = 3'b000;
        adc_base = 11'h064;
        {n_errors, tests_run, n_starts, n_clears, quiet} = '0;
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        t_reset();
        t_rate();
        t_standby();
        t_avg();
        t_crit();
        give_verdict();
    end
endmodule : thermal_ctrl_tb
`default_nettype wire
